// file: core/phase_timer.sv
// Phase capture timer with byte-buffered register pairs
`timescale 1ns/1ps
module phase_timer
  import phase_timer_pkg::*;
#(
  parameter int WAIT_BASE = 64 // Ticks of shortest wait window
) (
  input wire logic mclk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire timer_cfg_t cfg, // Mode, select and limit bits
  input wire logic run_set, // Pulse: software sets run enable
  input wire logic run_clr, // Pulse: software clears run enable
  input wire logic fast_clk_tick, // Enable pulse, fast-clock ratio
  input wire logic slow_clk_tick, // Enable pulse, low-speed clock
  input wire logic [1:0] sys_div_sel, // System clock ratio 1,2,4,8
  input wire logic zero_current_sig_0, // Comparator 0 zero-current
  input wire logic zero_current_sig_1, // Comparator 1 zero-current
  input wire logic phase_0, // Phase detector 0 output
  input wire logic phase_1, // Phase detector 1 output
  input wire logic capture_flag_clr, // Pulse: clear capture flag
  input wire logic overflow_flag_clr, // Pulse: clear overflow flag
  input wire byte_req_t req, // Byte read or write
  output logic [7:0] rdata, // Read data, valid cycle after rd
  output logic counter_run_enable, // Run enable state
  output logic capture_irq_flag, // Capture or window-end flag
  output logic overflow_irq_flag, // Timer overflow flag
  output logic [9:0] live_count, // Counter value
  output logic [11:0] pwm_period // Period register value
);

  // Longest window, WAIT_BASE shifted by seven, must fit the 17-bit counter
  if (WAIT_BASE < 1 || WAIT_BASE > 1023) begin : g_bad_wait_base
    $error("WAIT_BASE out of range");
  end

  // ----------------------------------------------------------------
  // Input synchronisers (three stages, agree on stages two and three)
  // ----------------------------------------------------------------
  logic [2:0] zc0_sync_reg, zc1_sync_reg, ph0_sync_reg, ph1_sync_reg;
  logic zc0_reg, zc1_reg, ph0_reg, ph1_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      zc0_sync_reg <= 3'h0;
      zc1_sync_reg <= 3'h0;
      ph0_sync_reg <= 3'h0;
      ph1_sync_reg <= 3'h0;
    end else begin
      zc0_sync_reg <= {zc0_sync_reg[1:0], zero_current_sig_0};
      zc1_sync_reg <= {zc1_sync_reg[1:0], zero_current_sig_1};
      ph0_sync_reg <= {ph0_sync_reg[1:0], phase_0};
      ph1_sync_reg <= {ph1_sync_reg[1:0], phase_1};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      zc0_reg <= 1'b0;
      zc1_reg <= 1'b0;
      ph0_reg <= 1'b0;
      ph1_reg <= 1'b0;
    end else begin
      if (zc0_sync_reg[2] == zc0_sync_reg[1]) zc0_reg <= zc0_sync_reg[2];
      if (zc1_sync_reg[2] == zc1_sync_reg[1]) zc1_reg <= zc1_sync_reg[2];
      if (ph0_sync_reg[2] == ph0_sync_reg[1]) ph0_reg <= ph0_sync_reg[2];
      if (ph1_sync_reg[2] == ph1_sync_reg[1]) ph1_reg <= ph1_sync_reg[2];
    end
  end

  // ----------------------------------------------------------------
  // Source selection and edge detection
  // ----------------------------------------------------------------
  logic event_input, phase_in, event_prev_reg, phase_prev_reg;
  logic event_rise, phase_rise, phase_fall, phase_edge;
  logic capture_mode;

  assign event_input = cfg.event_source_select ? zc1_reg : zc0_reg;
  assign phase_in = cfg.phase_source_select ? ph1_reg : ph0_reg;
  assign capture_mode = ~cfg.timer_mode_bit1;

  always_ff @(posedge mclk) begin
    if (rst) begin
      event_prev_reg <= 1'b0;
      phase_prev_reg <= 1'b0;
    end else begin
      event_prev_reg <= event_input;
      phase_prev_reg <= phase_in;
    end
  end

  assign event_rise = event_input & ~event_prev_reg;
  assign phase_rise = phase_in & ~phase_prev_reg;
  assign phase_fall = ~phase_in & phase_prev_reg;

  always_comb begin
    unique case (cfg.edge_select)
      EDGE_RISE: phase_edge = phase_rise;
      EDGE_FALL: phase_edge = phase_fall;
      default: phase_edge = phase_rise | phase_fall;
    endcase
  end

  // ----------------------------------------------------------------
  // Counter clock enable
  // ----------------------------------------------------------------
  logic [2:0] div_reg;
  logic count_tick;

  always_ff @(posedge mclk) begin
    if (rst) div_reg <= 3'h0;
    else div_reg <= div_reg + 3'h1;
  end

  always_comb begin
    unique case (cfg.counter_clock_select)
      3'h0: count_tick = 1'b1;
      3'h1: count_tick = (div_reg[0] == 1'b0);
      3'h2: count_tick = (div_reg[1:0] == 2'h0);
      3'h3: count_tick = (div_reg == 3'h0) && (sys_div_sel != 2'h0);
      3'h4: count_tick = fast_clk_tick;
      3'h5: count_tick = slow_clk_tick;
      3'h6: count_tick = (div_reg[1:0] == 2'h0) | sys_div_sel[1];
      default: count_tick = event_rise;
    endcase
  end

  // ----------------------------------------------------------------
  // Run enable, counter, wait window
  // ----------------------------------------------------------------
  logic run_prev_reg, run_start, window_end;
  logic [16:0] wait_cnt_reg;
  logic [16:0] wait_limit;

  assign run_start = counter_run_enable & ~run_prev_reg;
  // Window measured in slow-clock ticks so it is independent of source
  assign wait_limit = 17'(WAIT_BASE << cfg.wait_window_select);
  assign window_end = counter_run_enable & ~capture_mode & ~run_start
    & slow_clk_tick & (wait_cnt_reg + 17'h1 >= wait_limit);

  always_ff @(posedge mclk) begin
    if (rst) counter_run_enable <= 1'b0;
    else if (run_set) counter_run_enable <= 1'b1;
    else if (run_clr || window_end) counter_run_enable <= 1'b0;
  end

  always_ff @(posedge mclk) begin
    if (rst) run_prev_reg <= 1'b0;
    else run_prev_reg <= counter_run_enable;
  end

  always_ff @(posedge mclk) begin
    if (rst) wait_cnt_reg <= 17'h0;
    else if (run_start) wait_cnt_reg <= 17'h0;
    else if (counter_run_enable && slow_clk_tick)
      wait_cnt_reg <= wait_cnt_reg + 17'h1;
  end

  always_ff @(posedge mclk) begin
    if (rst) live_count <= CNT_RESET;
    else if (run_start) live_count <= CNT_RESET;
    else if (counter_run_enable && count_tick)
      live_count <= live_count + 10'h1;
  end

  // ----------------------------------------------------------------
  // Capture register and flags
  // ----------------------------------------------------------------
  logic [9:0] capture_value;
  logic cap_event, ovf_event, cap_write;
  logic [11:0] wr_pair;

  assign cap_event = (capture_mode & counter_run_enable & phase_edge)
    | window_end;
  assign ovf_event = ~capture_mode & counter_run_enable & count_tick
    & (live_count == CNT_MAX);

  always_ff @(posedge mclk) begin
    if (rst) capture_value <= CNT_RESET;
    else if (cap_event) capture_value <= live_count;
    else if (cap_write) capture_value <= wr_pair[9:0];
  end

  // Hardware set wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (rst) capture_irq_flag <= 1'b0;
    else if (cap_event) capture_irq_flag <= 1'b1;
    else if (capture_flag_clr) capture_irq_flag <= 1'b0;
  end

  always_ff @(posedge mclk) begin
    if (rst) overflow_irq_flag <= 1'b0;
    else if (ovf_event) overflow_irq_flag <= 1'b1;
    else if (overflow_flag_clr) overflow_irq_flag <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Byte-buffered register pairs
  // ----------------------------------------------------------------
  logic [7:0] low_buf_reg;
  logic [11:0] pair_reg [NUM_PAIRS];
  logic [11:0] pair_val [NUM_PAIRS];
  logic hi_wr, hi_rd, lo_rd;

  assign hi_wr = req.wr & req.high;
  assign hi_rd = req.rd & req.high;
  assign lo_rd = req.rd & ~req.high;
  assign wr_pair = {req.wdata[3:0], low_buf_reg};
  assign cap_write = hi_wr && (req.sel == SEL_CAPTURE);

  // Buffer: low write loads it, high read refills it
  always_ff @(posedge mclk) begin
    if (rst) low_buf_reg <= BYTE_RESET;
    else if (req.wr && !req.high) low_buf_reg <= req.wdata;
    else if (hi_rd && req.sel < 4'(NUM_PAIRS))
      low_buf_reg <= pair_val[req.sel][7:0];
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PAIRS; gi++) begin : g_pair
      if (gi == SEL_LIVE_COUNT) begin : g_live
        assign pair_reg[gi] = PAIR_RESET;
        assign pair_val[gi] = {2'h0, live_count};
      end else if (gi == SEL_CAPTURE) begin : g_cap
        assign pair_reg[gi] = PAIR_RESET;
        assign pair_val[gi] = {2'h0, capture_value};
      end else begin : g_store
        logic [11:0] store_reg;
        logic accept;
        // Limit compares the full assembled 12-bit value
        assign accept = (gi != SEL_PWM_PERIOD) || !cfg.period_limit_enable
          || (wr_pair <= pair_reg[SEL_PERIOD_UPPER]);
        always_ff @(posedge mclk) begin
          if (rst) store_reg <= PAIR_RESET;
          else if (hi_wr && req.sel == 4'(gi) && accept)
            store_reg <= wr_pair;
        end
        assign pair_reg[gi] = store_reg;
        assign pair_val[gi] = store_reg;
      end
    end
  endgenerate

  assign pwm_period = pair_reg[SEL_PWM_PERIOD];

  // High reads direct, low reads return the buffer
  always_ff @(posedge mclk) begin
    if (rst) rdata <= BYTE_RESET;
    else if (lo_rd) rdata <= low_buf_reg;
    else if (hi_rd && req.sel < 4'(NUM_PAIRS))
      rdata <= {4'h0, pair_val[req.sel][11:8]};
    else if (hi_rd) rdata <= BYTE_RESET;
  end

endmodule

// file: pkg/phase_timer_pkg.sv
// Constants and types shared by the phase capture timer
package phase_timer_pkg;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int CNT_W = 10;
  localparam int PAIR_W = 12;
  localparam logic [9:0] CNT_MAX = 10'h3ff;
  localparam logic [9:0] CNT_RESET = 10'h000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [11:0] PAIR_RESET = 12'h000;

  // ----------------------------------------------------------------
  // Byte-pair register selectors
  // ----------------------------------------------------------------
  localparam int NUM_PAIRS = 9;
  localparam logic [3:0] SEL_PWM_COUNTER = 4'h0;
  localparam logic [3:0] SEL_PWM_PERIOD = 4'h1;
  localparam logic [3:0] SEL_PWM_DUTY = 4'h2;
  localparam logic [3:0] SEL_DEAD_TIME_0 = 4'h3;
  localparam logic [3:0] SEL_DEAD_TIME_1 = 4'h4;
  localparam logic [3:0] SEL_PERIOD_UPPER = 4'h5;
  localparam logic [3:0] SEL_PERIOD_LOWER = 4'h6;
  localparam logic [3:0] SEL_LIVE_COUNT = 4'h7;
  localparam logic [3:0] SEL_CAPTURE = 4'h8;

  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [2:0] CLK_EVENT = 3'h7;
  // Wait windows in slow-clock ticks, by wait_window_select
  localparam int WAIT_BASE_LOG2 = 6;

  // Byte access from the CPU side
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] sel;
    logic high;
    logic [7:0] wdata;
  } byte_req_t;

  // Mode and control bits
  typedef struct packed {
    logic timer_mode_bit1;
    logic timer_mode_bit0;
    logic [1:0] edge_select;
    logic [2:0] counter_clock_select;
    logic [2:0] wait_window_select;
    logic event_source_select;
    logic phase_source_select;
    logic period_limit_enable;
  } timer_cfg_t;

endpackage

// file: sim/phase_sources.sv
// Behavioural phase detectors and zero-current comparators
`timescale 1ns/1ps
module phase_sources (
  input wire logic [1:0] ph_cmd, // Wanted phase levels
  input wire logic [1:0] zc_cmd, // Wanted comparator levels
  output logic phase_0, // Phase detector 0 output
  output logic phase_1, // Phase detector 1 output
  output logic zero_current_sig_0, // Comparator 0 output
  output logic zero_current_sig_1 // Comparator 1 output
);
  // Always driven levels, so the synchronisers never see an unknown
  assign {phase_1, phase_0} = ph_cmd;
  assign {zero_current_sig_1, zero_current_sig_0} = zc_cmd;
endmodule

// file: sim/phase_timer_sva.sv
// Port-level assertions for the phase capture timer
`timescale 1ns/1ps
module phase_timer_sva
  import phase_timer_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic rst, // Sync reset
  input wire timer_cfg_t cfg, // Config bits
  input wire logic run_set, // Run set pulse
  input wire logic run_clr, // Run clear pulse
  input wire byte_req_t req, // Byte access
  input wire logic [7:0] rdata, // Read data
  input wire logic counter_run_enable, // Run state
  input wire logic capture_irq_flag, // Capture flag
  input wire logic overflow_irq_flag, // Overflow flag
  input wire logic [9:0] live_count, // Counter
  input wire logic [11:0] pwm_period // Period register
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic hi_wr;
  logic hi_rd;
  logic [11:0] per_q;
  logic [11:0] per_q2;
  assign hi_wr = req.wr && req.high && req.sel == SEL_PWM_PERIOD;
  assign hi_rd = req.rd && req.high && req.sel == SEL_PWM_PERIOD;
  // Delayed copies let reads be tied to the value at request time
  always_ff @(posedge mclk) begin
    per_q <= pwm_period;
    per_q2 <= per_q;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_start;
    $rose(counter_run_enable) |-> $past(run_set);
  endproperty
  a_start: assert property (p_start) else $error("run w/o set");
  property p_low;
    !hi_wr |=> $stable(pwm_period);
  endproperty
  a_low: assert property (p_low) else $error("period moved");
  property p_hi_wr;
    hi_wr && !cfg.period_limit_enable |=>
      pwm_period[11:8] == $past(req.wdata[3:0]);
  endproperty
  a_hi_wr: assert property (p_hi_wr) else $error("bad high");
  property p_hi_rd;
    hi_rd |=> rdata == {4'h0, per_q[11:8]};
  endproperty
  a_hi_rd: assert property (p_hi_rd) else $error("bad high rd");
  property p_lo_rd;
    hi_rd ##1 (req.rd && !req.high) |=> rdata == per_q2[7:0];
  endproperty
  a_lo_rd: assert property (p_lo_rd) else $error("bad low rd");
  property p_free;
    counter_run_enable && !run_clr && !cfg.timer_mode_bit1
      |=> counter_run_enable;
  endproperty
  a_free: assert property (p_free) else $error("capture stop");
  property p_wrap;
    $rose(overflow_irq_flag) |-> $past(cfg.timer_mode_bit1) &&
      $past(live_count) == CNT_MAX && live_count == CNT_RESET;
  endproperty
  a_wrap: assert property (p_wrap) else $error("bad overflow");
  property p_window;
    $fell(counter_run_enable) && !$past(run_clr) |-> capture_irq_flag;
  endproperty
  a_window: assert property (p_window) else $error("no flag");
  property p_hold;
    !counter_run_enable ##1 !counter_run_enable |-> $stable(live_count);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved");
  c_cap: cover property ($rose(capture_irq_flag));
  c_ovf: cover property ($rose(overflow_irq_flag));
  c_lim: cover property (hi_wr && cfg.period_limit_enable);
endmodule
bind phase_timer phase_timer_sva phase_timer_sva_inst (.mclk(mclk),
  .rst(rst), .cfg(cfg), .run_set(run_set), .run_clr(run_clr),
  .req(req), .rdata(rdata), .counter_run_enable(counter_run_enable),
  .capture_irq_flag(capture_irq_flag),
  .overflow_irq_flag(overflow_irq_flag), .live_count(live_count),
  .pwm_period(pwm_period));

// file: sim/phase_timer_tb.sv
// Self-checking bench for the phase capture timer
`timescale 1ns/1ps
module phase_timer_tb;
  import phase_timer_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  timer_cfg_t cfg = '0;
  logic run_set = 1'b0;
  logic run_clr = 1'b0;
  logic slow_clk_tick = 1'b0;
  logic slow_on = 1'b0;
  logic fast_tick = 1'b0;
  logic cap_clr = 1'b0;
  logic ovf_clr = 1'b0;
  byte_req_t req = '0;
  logic [1:0] ph = 2'h0;
  logic [1:0] zc = 2'h0;
  logic ph0, ph1, zc0, zc1, run_en, cap_f, ovf_f;
  logic [7:0] rdata;
  logic [9:0] live_count;
  logic [11:0] pwm_period;
  logic [11:0] v;
  logic [11:0] c;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  always #2 mclk = ~mclk;
  phase_sources phase_sources_inst (.ph_cmd(ph), .zc_cmd(zc),
    .phase_0(ph0), .phase_1(ph1), .zero_current_sig_0(zc0),
    .zero_current_sig_1(zc1));
  phase_timer #(.WAIT_BASE(4)) phase_timer_inst (.mclk(mclk), .rst(rst),
    .cfg(cfg), .run_set(run_set), .run_clr(run_clr),
    .fast_clk_tick(fast_tick), .slow_clk_tick(slow_clk_tick),
    .sys_div_sel(2'h0), .zero_current_sig_0(zc0),
    .zero_current_sig_1(zc1), .phase_0(ph0), .phase_1(ph1),
    .capture_flag_clr(cap_clr), .overflow_flag_clr(ovf_clr), .req(req),
    .rdata(rdata), .counter_run_enable(run_en), .capture_irq_flag(cap_f),
    .overflow_irq_flag(ovf_f), .live_count(live_count),
    .pwm_period(pwm_period));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] s, input logic h,
                     input logic [7:0] d);
    req = '{w, !w, s, h, d};
    tick();
  endtask
  task automatic wr_pair(input logic [3:0] s, input logic [11:0] d);
    acc(1'b1, s, 1'b0, d[7:0]);
    acc(1'b1, s, 1'b1, {4'h0, d[11:8]});
    req = '0;
    tick();
  endtask
  task automatic rd_pair(input logic [3:0] s, output logic [11:0] d);
    acc(1'b0, s, 1'b1, 8'h00);
    d[11:8] = rdata[3:0];
    acc(1'b0, s, 1'b0, 8'h00);
    d[7:0] = rdata;
    req = '0;
    tick();
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_pairs();
    for (int s = 1; s < 7; s++) begin
      wr_pair(s[3:0], 12'h0a5 + 12'h111 * s[11:0]);
      rd_pair(s[3:0], v);
      chk(v, 12'h0a5 + 12'h111 * s[11:0]);
    end
    chk(pwm_period, 12'h1b6);
    acc(1'b1, SEL_PWM_PERIOD, 1'b0, 8'h3c);
    req = '0;
    tick();
    chk(pwm_period, 12'h1b6);
    wr_pair(SEL_PWM_PERIOD, 12'ha3c);
    chk(pwm_period, 12'ha3c);
    acc(1'b0, SEL_PWM_DUTY, 1'b1, 8'h00);
    acc(1'b0, SEL_PWM_PERIOD, 1'b0, 8'h00);
    req = '0;
    chk({4'h0, rdata}, 12'h0c7);
  endtask
  task automatic s_limit();
    wr_pair(SEL_PERIOD_UPPER, 12'h400);
    cfg.period_limit_enable = 1'b1;
    wr_pair(SEL_PWM_PERIOD, 12'h401);
    chk(pwm_period, 12'ha3c);
    wr_pair(SEL_PWM_PERIOD, 12'h400);
    chk(pwm_period, 12'h400);
    cfg.period_limit_enable = 1'b0;
  endtask
  task automatic s_capture();
    cfg = '0;
    pulse(run_set);
    tick(8);
    for (int e = 0; e < 3; e++) begin
      cfg.edge_select = e[1:0];
      cfg.timer_mode_bit0 = e[0];
      cfg.phase_source_select = e[0];
      pulse(cap_clr);
      ph[!e[0]] = 1'b1;
      tick(10);
      chk(cap_f, 1'b0);
      ph = 2'h3;
      tick(10);
      chk(cap_f, e != 1);
      pulse(cap_clr);
      ph[e[0]] = 1'b0;
      tick(10);
      chk(cap_f, e != 0);
      ph = 2'h0;
      tick(10);
    end
    rd_pair(SEL_CAPTURE, c);
    tick(20);
    rd_pair(SEL_CAPTURE, v);
    chk(v, c);
    // Last capture: fall of phase 0, 117 counts after the counter cleared at run start
    chk(c, 12'h075);
    tick(1100);
    chk(ovf_f, 1'b0);
    chk(run_en, 1'b1);
    pulse(run_clr);
    chk(run_en, 1'b0);
  endtask
  task automatic s_timer();
    cfg = '0;
    cfg.timer_mode_bit1 = 1'b1;
    pulse(run_set);
    for (int i = 0; i < 1100 && ovf_f !== 1'b1; i++) tick();
    chk(ovf_f, 1'b1);
    pulse(ovf_clr);
    chk(ovf_f, 1'b0);
    pulse(run_clr);
    v = {2'h0, live_count};
    tick(20);
    chk({2'h0, live_count}, v);
  endtask
  task automatic s_event();
    cfg.counter_clock_select = CLK_EVENT;
    cfg.event_source_select = 1'b1;
    slow_on = 1'b1;
    pulse(cap_clr);
    pulse(run_set);
    tick(4);
    // Comparator 0 pulses twice as often, so a wrong source shows
    repeat (3) begin
      zc = 2'h3;
      tick(6);
      zc = 2'h0;
      tick(6);
      zc = 2'h1;
      tick(6);
      zc = 2'h0;
      tick(6);
    end
    for (int i = 0; i < 600 && run_en === 1'b1; i++) tick();
    chk(run_en, 1'b0);
    chk(cap_f, 1'b1);
    rd_pair(SEL_CAPTURE, v);
    chk(v, 12'h003);
    slow_on = 1'b0;
  endtask
  // Counter left at 3 by the window; 5 proves both the clear and the source
  task automatic s_clock();
    cfg = '0;
    cfg.counter_clock_select = 3'h4;
    pulse(run_set);
    tick(2);
    repeat (5) begin
      pulse(fast_tick);
      tick();
    end
    pulse(run_clr);
    chk({2'h0, live_count}, 12'h005);
  endtask
  always @(posedge mclk) begin
    cycles++;
    slow_clk_tick <= slow_on && cycles[5:0] == 6'h00;
    if (cycles == 10000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    tick(10);
    rst = 1'b0;
    s_pairs();
    s_limit();
    s_capture();
    s_timer();
    s_event();
    s_clock();
    give_verdict();
  end
endmodule
